/* File: core/rop_pkg.sv */
// How it works
// - Decode four consecutive byte addresses from base
// - Write offset 0 loads eight-bit relay latch
// - Read offset 0 returns relay state
// - Read offset 1 returns inputs, channel n bit n
// - Latch bit n drives relay n
// - Set bit energises relay toward make contact
// - Power-on clears latch, relays at break contact
// - Select by matching A9..A2 with switch value
// - Channel 0 edge raises interrupt, rising default
// - Gated mode: channel 4 enables interrupt
`default_nettype none
package rop_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int SEL_W = 8;
    localparam logic [1:0] OFF_RELAY = 2'h0;
    localparam logic [1:0] OFF_INPUT = 2'h1;
    localparam logic [DATA_W-1:0] RELAY_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
    localparam int GATE_CH = 4;
    localparam int IRQ_CH = 0;

    // Host bus request, one cycle wide per strobe
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } rop_req_t;
endpackage : rop_pkg
`default_nettype wire

/* File: core/rop_port.sv */
`default_nettype none

// Two-flop synchroniser for levels that arrive from outside the clock domain.
// One module serves the input channels, the jumpers and the base switches,
// so every pin crosses the same way and only one circuit needs checking.
module rop_sync #(
    parameter int W = 8 // Width of the bus being synchronised
) (
    input wire logic mclk, // 100 MHz clock
    input wire logic [W-1:0] pinIn, // Asynchronous pin levels
    output logic [W-1:0] pinSync // Levels after two flops
);
    // First stage may go metastable; only the second stage reads it
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;

    // Second stage is the only copy the logic may use
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Next values of both stages
    always_comb begin
        meta_d = pinIn;
        sync_d = meta_q;
    end

    // No reset: pin levels flush through within two edges anyway
    always_ff @(posedge mclk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    // Synchronised level out
    assign pinSync = sync_q;
endmodule : rop_sync

// Host-side port: relay latch, readback, input read and channel 0 interrupt.
// Requests arrive as one-cycle strobes on the clock, so they need no crossing.
module rop_port (
    input wire logic mclk, // 100 MHz clock
    input wire logic reset, // Sync reset, active high
    input wire rop_pkg::rop_req_t hostReq, // Host strobe, address, data
    input wire logic [rop_pkg::SEL_W-1:0] baseSelectSwitch, // Base A9..A2
    input wire logic [rop_pkg::DATA_W-1:0] isolatedInputChannel, // Input pins
    input wire logic edgeSelectJumper, // 0 rising, 1 falling
    input wire logic gateSelectJumper, // 1 gated by channel 4
    output logic [rop_pkg::DATA_W-1:0] hostRdata, // Read data
    output logic hostRvalid, // Read data valid pulse
    output logic [rop_pkg::DATA_W-1:0] relayDriveBit, // Relay coil drive
    output logic hostIrq // Interrupt pulse
);
    import rop_pkg::*;

    // Synchronised copies of the pins
    logic [DATA_W-1:0] inSync;
    logic [SEL_W-1:0] baseSync;
    logic [1:0] jmpSync;

    // Relay latch state
    logic [DATA_W-1:0] relay_q;
    logic [DATA_W-1:0] relay_d;

    // Read path state
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    // Interrupt state and channel history
    logic [DATA_W-1:0] inPrev_q;
    logic [DATA_W-1:0] inPrev_d;
    logic irq_q;
    logic irq_d;

    // Decode results
    logic hit;
    logic [1:0] offs;
    logic wrRelay;
    logic rdHit;

    // Edge detect terms
    logic edgeRise;
    logic edgeFall;
    logic edgeSeen;
    logic gateOpen;

    // Input channels cross into the clock domain here
    rop_sync #(
        .W(DATA_W)
    ) inSyncU (
        .mclk(mclk),
        .pinIn(isolatedInputChannel),
        .pinSync(inSync)
    );

    // Jumpers: bit 1 gate select, bit 0 edge select
    rop_sync #(
        .W(2)
    ) jmpSyncU (
        .mclk(mclk),
        .pinIn({gateSelectJumper, edgeSelectJumper}),
        .pinSync(jmpSync)
    );

    // Switches are static, but still cross two flops like any other pin.
    // A switch moved while the host is busy may miss one access; harmless.
    rop_sync #(
        .W(SEL_W)
    ) baseSyncU (
        .mclk(mclk),
        .pinIn(baseSelectSwitch),
        .pinSync(baseSync)
    );

    // Address decode ignores A1..A0 so the window spans four bytes
    assign hit = (hostReq.addr[ADDR_W-1:2] == baseSync);
    assign offs = hostReq.addr[1:0];

    // Only offset 0 writes reach the latch; all other writes are dropped
    assign wrRelay = hit && hostReq.wr && (offs == OFF_RELAY);
    assign rdHit = hit && hostReq.rd;

    // Relay latch next value
    always_comb begin
        relay_d = relay_q;
        if (wrRelay) begin
            relay_d = hostReq.wdata;
        end
    end

    // Relay latch register; reset leaves every relay at its break contact
    always_ff @(posedge mclk) begin
        if (reset) begin
            relay_q <= RELAY_RESET;
        end else begin
            relay_q <= relay_d;
        end
    end

    // Read data next value; it holds until the next read, so a slow host
    // may sample it late. A read and a write in one cycle see the old latch.
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (rdHit) begin
            rvalid_d = 1'b1;
            case (offs)
                OFF_RELAY: begin
                    rdata_d = relay_q;
                end
                OFF_INPUT: begin
                    rdata_d = inSync;
                end
                default: begin
                    rdata_d = READ_IDLE;
                end
            endcase
        end
    end

    // Read path register
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_q <= READ_IDLE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Edge detect on channel 0 against last cycle's synchronised level
    always_comb begin
        edgeRise = inSync[IRQ_CH] & ~inPrev_q[IRQ_CH];
        edgeFall = ~inSync[IRQ_CH] & inPrev_q[IRQ_CH];
    end

    // Edge select, then the optional gate from channel 4.
    // The pulse is one cycle wide; there is no sticky flag to clear.
    always_comb begin
        edgeSeen = jmpSync[0] ? edgeFall : edgeRise;
        gateOpen = ~jmpSync[1] | inSync[GATE_CH];
        irq_d = edgeSeen & gateOpen;
        inPrev_d = inSync;
    end

    // Interrupt register. History loads the live level during reset, so an
    // input held high across reset gives no false edge after release.
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_q <= 1'b0;
            inPrev_q <= inSync;
        end else begin
            irq_q <= irq_d;
            inPrev_q <= inPrev_d;
        end
    end

    // Outputs straight from flops; bit n high energises relay n
    assign relayDriveBit = relay_q;
    assign hostRdata = rdata_q;
    assign hostRvalid = rvalid_q;
    assign hostIrq = irq_q;
endmodule : rop_port
`default_nettype wire

/* File: tb/rop_props.sv */
`default_nettype none
module rop_props import rop_pkg::*; (
    input wire logic mclk, input wire logic reset, input wire rop_req_t hostReq, // Bus side
    input wire logic [7:0] baseSelectSwitch, input wire logic [7:0] hostRdata, // Select, data
    input wire logic hostRvalid, input wire logic [7:0] relayDriveBit, input wire logic hostIrq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Decode shared by the relay and read properties
    wire logic hit = hostReq.addr[9:2] == baseSelectSwitch;
    wire logic [1:0] off = hostReq.addr[1:0];
    a_relay_load: assert property (hit && hostReq.wr && off == 0
        |=> relayDriveBit == $past(hostReq.wdata)) else $error("relay load");
    a_relay_hold: assert property (!(hit && hostReq.wr && off == 0)
        |=> $stable(relayDriveBit)) else $error("relay changed");
    a_read_back: assert property (hit && hostReq.rd && off == 0
        |=> hostRvalid && hostRdata == $past(relayDriveBit)) else $error("readback");
    a_read_quiet: assert property (!(hit && hostReq.rd) |=> !hostRvalid)
        else $error("stray rvalid");
    a_read_idle: assert property (hit && hostReq.rd && off[1]
        |=> hostRvalid && hostRdata == 0) else $error("idle read");
    a_rdata_hold: assert property (!hostRvalid && !$past(reset) |-> $stable(hostRdata))
        else $error("rdata moved");
    a_reset_clear: assert property (disable iff (1'b0) reset
        |=> relayDriveBit == 0 && !hostRvalid) else $error("reset state");
    a_irq_pulse: assert property (hostIrq |=> !hostIrq) else $error("irq width");
    cover property (hit && hostReq.wr && off == 0);
    cover property (hostRvalid);
    cover property (hostIrq);
endmodule : rop_props
bind rop_port rop_props P (.mclk, .reset, .hostReq, .baseSelectSwitch, .hostRdata,
    .hostRvalid, .relayDriveBit, .hostIrq);
`default_nettype wire

/* File: tb/rop_host.sv */
`default_nettype none
module rop_host import rop_pkg::*; (
    input wire logic mclk, // Bus clock
    output var rop_pkg::rop_req_t hostReq // Strobe, address, data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial hostReq = '0;
    // One strobe per call; lines scrambled once released so stale values never match
    task automatic op(input logic [9:0] a, input logic [7:0] d, input logic w);
        @(posedge mclk) #1 hostReq = '{a, d, w, !w};
        @(posedge mclk) #1 hostReq = '{~a, ~d, 1'b0, 1'b0};
    endtask : op
endmodule : rop_host
`default_nettype wire

/* File: tb/relay_output_isolated_input_port_tb.sv */
`default_nettype none
module relay_output_isolated_input_port_tb;
    import rop_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, reset = 1, rvalid, irq, hitRd, expIrq;
    logic edgeSel = 0, gateSel = 0;
    logic [7:0] din = 0, rdata, relay, m = 0, prevDin = 0;
    logic [7:0] readQ[$];
    rop_req_t hostReq;
    int errorCnt = 0, samplesChecked = 0;
    logic [31:0] x = 12244;
    always #5 mclk = ~mclk;
    rop_host H (.mclk, .hostReq);
    rop_port DUT (.mclk, .reset, .hostReq, .baseSelectSwitch(8'hC0),
        .isolatedInputChannel(din), .edgeSelectJumper(edgeSel),
        .gateSelectJumper(gateSel), .hostRdata(rdata),
        .hostRvalid(rvalid), .relayDriveBit(relay), .hostIrq(irq));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        r = r ^ (r << 5);
        return r;
    endfunction : xorshift
    task automatic report(string n, logic [7:0] e, logic [7:0] s);
        samplesChecked++;
        if (s !== e) begin
            errorCnt++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask : report
    task automatic chkRelay(logic [7:0] e);
        report("relay", e, relay);
    endtask : chkRelay
    // Read result: strobe always, data popped from the model's queue on a hit
    task automatic chkRead(logic e);
        report("rvalid", {7'h00, e}, {7'h00, rvalid});
        if (e) report("rdata", readQ.pop_front(), rdata);
    endtask : chkRead
    task automatic chkIrq(logic e);
        report("irq", {7'h00, e}, {7'h00, irq});
    endtask : chkIrq
    task automatic wrapUp;
        if (errorCnt == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrapUp
    // Random mix of hits, misses, reads and writes over all four offsets
    initial begin
        repeat (10) @(posedge mclk);
        #1 reset = 0;
        chkRelay(8'h00);
        for (int i = 0; i < 200; i++) begin
            x = xorshift(x);
            din = x[31:24];
            edgeSel = x[22];
            gateSel = x[23];
            // Pin edge reaches the interrupt flop on the third edge
            expIrq = (edgeSel ? (prevDin[0] & !din[0]) : (din[0] & !prevDin[0]))
                & (!gateSel | din[4]);
            repeat (3) @(posedge mclk);
            #1 chkIrq(expIrq);
            prevDin = din;
            hitRd = x[9] & !x[20];
            if (hitRd) readQ.push_back(x[1:0] == 0 ? m : x[1:0] == 1 ? din : 8'h00);
            H.op(x[9] ? {8'hC0, x[1:0]} : x[9:0], x[17:10], x[20]);
            chkRead(hitRd);
            if (x[9] & x[20] & x[1:0] == 0) m = x[17:10];
            chkRelay(m);
        end
        reset = 1;
        @(posedge mclk) #1 reset = 0;
        chkRelay(8'h00);
        chkRead(1'b0);
        report("rdata", 8'h00, rdata);
        H.op(10'h300, 8'h5A, 1'b1);
        chkRelay(8'h5A);
        chkIrq(1'b0);
        wrapUp();
    end
    // Hang guard, well beyond the loop's length
    initial begin #100000; errorCnt++; wrapUp(); end
endmodule : relay_output_isolated_input_port_tb
`default_nettype wire
